//--- rtl/adsq_pkg.sv
// Package with register map, field layout and timing constants of the converter sequencer.
package adsq_pkg;
    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL_LOW  = 8'h9c;
    localparam logic [7:0] ADDR_CTRL_HIGH = 8'h9d;
    localparam logic [7:0] ADDR_RES_LOW   = 8'h9e;
    localparam logic [7:0] ADDR_RES_HIGH  = 8'h9f;
    // Control low field positions.
    localparam int BIT_POWER   = 7;
    localparam int BIT_START   = 6;
    localparam int BIT_REFERENCE_SELECT  = 5;
    localparam int BIT_DONE    = 4;
    // Control high field positions.
    localparam int BIT_IRQ     = 7;
    localparam int BIT_ALIGN   = 2;
    // Reset value of control registers.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Trigger select codes.
    localparam logic [2:0] TRIGGER_SELECT_SOFT  = 3'h0;
    localparam logic [2:0] TRIGGER_SELECT_T1CA  = 3'h1;
    localparam logic [2:0] TRIGGER_SELECT_T4OV  = 3'h2;
    localparam logic [2:0] TRIGGER_SELECT_T4CA  = 3'h3;
    localparam logic [2:0] TRIGGER_SELECT_T4CB  = 3'h4;
    localparam logic [2:0] TRIGGER_SELECT_T4CC  = 3'h5;
    // Sequencer timing in conversion clocks.
    localparam int RES_BITS       = 12;
    localparam int SETUP_CLOCKS   = 10;
    localparam int CLOCKS_PER_BIT = 4;
    localparam int TOTAL_CLOCKS   = SETUP_CLOCKS + CLOCKS_PER_BIT * RES_BITS;
    localparam logic [5:0] LAST_TICK = 6'(TOTAL_CLOCKS - 1);
    localparam logic [5:0] SETUP_LAST = 6'(SETUP_CLOCKS - 1);
    // Timer event bundle.
    typedef struct packed {
        logic t1_cmp_a;
        logic t4_ovf;
        logic t4_cmp_a;
        logic t4_cmp_b;
        logic t4_cmp_c;
    } adsq_tmr_t;
    // Sequencer states.
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_BITS} adsq_state_t;
endpackage : adsq_pkg

//--- rtl/adsq_clkdiv.sv
// Conversion clock tick generator dividing the system clock by 1, 2, 4 or 8.
`timescale 1ns/100ps
module adsq_clkdiv
(
    // Clock and reset.
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // Control.
    input  wire logic       i_run,
    input  wire logic [1:0] i_sel,
    // Tick out.
    output logic            o_tick
);
    logic [2:0] cnt_r;   // Prescale counter.
    logic [2:0] mask;    // Counter bits that must be all ones for a tick.
    logic       tick_r;  // Registered tick.

    // Code n divides by two to the n.
    assign mask = (i_sel == 2'h0) ? 3'h0 : (i_sel == 2'h1) ? 3'h1 : (i_sel == 2'h2) ? 3'h3 : 3'h7; // RQ9

    // Counter restarts whenever the sequencer is idle so every conversion sees full-length clocks.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !i_run)
        begin
            cnt_r  <= 3'h0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_r + 3'h1;
            tick_r <= ((cnt_r & mask) == mask); // RQ9
        end
    end

    assign o_tick = tick_r;
endmodule : adsq_clkdiv

//--- rtl/adsq_seq.sv
// Converter sequencer with register file, triggers, successive-approximation control and result alignment.
//
// Contract
// RQ1: Twelve-bit result for selected channel.
// RQ2: At end load result, set done, interrupt.
// RQ3: Done flag reads zero while converting.
// RQ4: Ten setup clocks, four per bit, 58.
// RQ5: Software keeps conversion time above 20 us.
// RQ6: Alignment bit picks left or right justification.
// RQ7: Irq flag sets; write zero or ack clears.
// RQ8: Trigger select picks soft start or timers.
// RQ9: Conversion clock divides system clock 1/2/4/8.
// RQ10: Power enable bit; stop mode disables module.
// RQ11: Start bit starts conversion, clears itself.
// RQ12: Reference select: internal supply or external pin.
// RQ13: Done flag forced zero when disabled, stopped.
// RQ14: Channel code n routes analog input n.
// RQ15: Result read-only, undefined; control resets zero.
// RQ16: Selected timer event starts conversion when enabled.
`timescale 1ns/100ps
module adsq_seq
(
    // Clock and reset.
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    // Register port.
    input  wire logic [7:0]        i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [7:0]             o_rdata,
    // System state and interrupt acknowledge.
    input  wire logic              i_stop_mode,
    input  wire logic              i_irq_ack,
    // Timer events, one-cycle pulses from the same clock.
    input  wire adsq_pkg::adsq_tmr_t i_tmr,
    // Comparator from the analog core, asynchronous.
    input  wire logic              i_cmp_high,
    // Analog core controls.
    output logic                   o_core_enable,
    output logic [3:0]             o_channel_select,
    output logic                   o_reference_select,
    output logic                   o_sample,
    output logic [11:0]            o_dac_code,
    // Interrupt request level.
    output logic                   o_irq
);
    // Control fields.
    logic        power_r;          // Module power enable.
    logic        start_r;          // Soft start bit.
    logic        ref_r;            // Reference select.
    logic        done_r;           // Completion flag.
    logic [3:0]  chan_r;           // Channel select.
    logic        irq_r;            // Converter irq flag.
    logic [2:0]  trigger_select_r;           // Trigger select.
    logic        align_r;          // Right-justify when set.
    logic [1:0]  conv_clock_select_r;          // Conversion clock select.
    // Conversion state.
    adsq_pkg::adsq_state_t state_r;
    adsq_pkg::adsq_state_t state_nxt;
    logic [5:0]  tick_cnt_r;       // Conversion clocks since start.
    logic [11:0] sar_r;            // Trial code being built.
    logic [3:0]  bit_idx_r;        // Bit under trial.
    logic [11:0] result_r;         // Last finished result.
    logic [7:0]  rdata_r;          // Read data register.
    logic        cmp_s1_r;         // Comparator synchroniser stage one.
    logic        cmp_s2_r;         // Comparator synchroniser stage two.
    logic        sample_r;         // Sample window output.
    logic [11:0] dac_r;            // Trial code shown to the core.
    logic        core_en_r;        // Core power, off in stop mode too.
    logic [3:0]  setup_seen_r;     // Setup ticks seen, cross-check only.
    logic [5:0]  bits_seen_r;      // Bit-phase ticks seen, cross-check only.

    // Decode wires.
    logic        enabled;
    logic        wr_low;
    logic        wr_high;
    logic        tmr_hit;
    logic        trigger;
    logic        conv_tick;
    logic        busy;
    logic        bit_decide;
    logic        finish;
    logic [7:0]  res_high;
    logic [7:0]  res_low;
    logic [7:0]  rd_mux;
    logic [11:0] trial;

    // Stop mode overrides the enable bit.
    assign enabled = power_r && !i_stop_mode; // RQ10
    assign wr_low  = i_wr && (i_addr == adsq_pkg::ADDR_CTRL_LOW);
    assign wr_high = i_wr && (i_addr == adsq_pkg::ADDR_CTRL_HIGH);

    // Timer event selected by the trigger code; unused codes pick nothing.
    assign tmr_hit = (trigger_select_r == adsq_pkg::TRIGGER_SELECT_T1CA) ? i_tmr.t1_cmp_a :
                     (trigger_select_r == adsq_pkg::TRIGGER_SELECT_T4OV) ? i_tmr.t4_ovf   :
                     (trigger_select_r == adsq_pkg::TRIGGER_SELECT_T4CA) ? i_tmr.t4_cmp_a :
                     (trigger_select_r == adsq_pkg::TRIGGER_SELECT_T4CB) ? i_tmr.t4_cmp_b :
                     (trigger_select_r == adsq_pkg::TRIGGER_SELECT_T4CC) ? i_tmr.t4_cmp_c : 1'b0; // RQ8
    // Triggers during a running conversion are dropped, except the soft bit which waits.
    assign trigger = enabled && (state_r == adsq_pkg::ST_IDLE) &&
                     (((trigger_select_r == adsq_pkg::TRIGGER_SELECT_SOFT) && start_r) || tmr_hit); // RQ11 RQ16
    assign busy    = (state_r != adsq_pkg::ST_IDLE);

    // Conversion clock from the divider.
    adsq_clkdiv u_div
    (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_run     (busy && enabled),
        .i_sel     (conv_clock_select_r), // RQ9
        .o_tick    (conv_tick)
    );

    // Each bit decides on the last of its four conversion clocks.
    assign bit_decide = conv_tick && (state_r == adsq_pkg::ST_BITS) &&
                        (tick_cnt_r[1:0] == 2'(adsq_pkg::CLOCKS_PER_BIT - 1 + adsq_pkg::SETUP_CLOCKS)); // RQ4
    assign finish     = conv_tick && (state_r == adsq_pkg::ST_BITS) && (tick_cnt_r == adsq_pkg::LAST_TICK); // RQ4
    assign trial      = sar_r | (12'h001 << bit_idx_r);

    // Next state of the sequencer.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            adsq_pkg::ST_IDLE:
                if (trigger)
                    state_nxt = adsq_pkg::ST_SETUP;
            adsq_pkg::ST_SETUP:
                if (conv_tick && (tick_cnt_r == adsq_pkg::SETUP_LAST))
                    state_nxt = adsq_pkg::ST_BITS; // RQ4
            adsq_pkg::ST_BITS:
                if (finish)
                    state_nxt = adsq_pkg::ST_IDLE;
            default:
                state_nxt = adsq_pkg::ST_IDLE;
        endcase
        // Disabling aborts any conversion in flight.
        if (!enabled)
            state_nxt = adsq_pkg::ST_IDLE; // RQ10
    end

    // Comparator comes from the analog domain, so it is double-registered.
    always_ff @(posedge i_clk_sys)
    begin
        cmp_s1_r <= i_cmp_high;
        cmp_s2_r <= cmp_s1_r;
    end

    // Sequencer state, tick count and trial code.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            state_r    <= adsq_pkg::ST_IDLE;
            tick_cnt_r <= 6'h00;
            sar_r      <= 12'h000;
            bit_idx_r  <= 4'hb;
        end
        else
        begin
            state_r <= state_nxt;
            if (trigger)
            begin
                tick_cnt_r <= 6'h00;
                sar_r      <= 12'h000;
                bit_idx_r  <= 4'(adsq_pkg::RES_BITS - 1); // RQ1
            end
            else if (conv_tick && busy)
            begin
                tick_cnt_r <= tick_cnt_r + 6'h01;
            end
            // Keep the trial bit only when the comparator says the input is above it.
            if (bit_decide)
            begin
                sar_r     <= cmp_s2_r ? trial : sar_r; // RQ1
                bit_idx_r <= bit_idx_r - 4'h1;
            end
        end
    end

    // Result register: no reset, contents undefined until the first conversion.
    always_ff @(posedge i_clk_sys)
    begin
        if (finish)
            result_r <= cmp_s2_r ? trial : sar_r; // RQ2 RQ15
    end

    // Control low register: power, start, reference, done flag and channel.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            power_r <= 1'b0; // RQ15
            start_r <= 1'b0;
            ref_r   <= 1'b0;
            chan_r  <= 4'h0;
        end
        else if (wr_low)
        begin
            power_r <= i_wdata[adsq_pkg::BIT_POWER];
            // Writing zero leaves a pending start untouched.
            start_r <= start_r | i_wdata[adsq_pkg::BIT_START]; // RQ11
            ref_r   <= i_wdata[adsq_pkg::BIT_REFERENCE_SELECT];
            chan_r  <= i_wdata[3:0];
        end
        else if (trigger || !enabled)
        begin
            start_r <= 1'b0; // RQ11
        end
    end

    // Done flag: cleared at start, set at finish, held low while disabled.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !enabled)
            done_r <= 1'b0; // RQ13
        else if (finish)
            done_r <= 1'b1; // RQ2
        else if (trigger)
            done_r <= 1'b0; // RQ3
    end

    // Control high register with the sticky interrupt flag; a finish beats a clear.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            irq_r   <= 1'b0;
            trigger_select_r  <= 3'h0;
            align_r <= 1'b0;
            conv_clock_select_r <= 2'h0;
        end
        else
        begin
            if (finish)
                irq_r <= 1'b1; // RQ2 RQ7
            else if (i_irq_ack || (wr_high && !i_wdata[adsq_pkg::BIT_IRQ]))
                irq_r <= 1'b0; // RQ7
            if (wr_high)
            begin
                trigger_select_r  <= i_wdata[5:3];
                align_r <= i_wdata[adsq_pkg::BIT_ALIGN];
                conv_clock_select_r <= i_wdata[1:0];
            end
        end
    end

    // Result justification.
    assign res_high = align_r ? {4'h0, result_r[11:8]} : result_r[11:4]; // RQ6
    assign res_low  = align_r ? result_r[7:0] : {result_r[3:0], 4'h0};  // RQ6

    // Read multiplexer; done reads zero while busy, unmapped addresses read zero.
    assign rd_mux =
        (i_addr == adsq_pkg::ADDR_CTRL_LOW)  ? {power_r, start_r, ref_r, done_r && !busy, chan_r} : // RQ3
        (i_addr == adsq_pkg::ADDR_CTRL_HIGH) ? {irq_r, 1'b0, trigger_select_r, align_r, conv_clock_select_r} :
        (i_addr == adsq_pkg::ADDR_RES_LOW)   ? res_low :
        (i_addr == adsq_pkg::ADDR_RES_HIGH)  ? res_high : 8'h00;

    // Read data stand in the cycle after the strobe only.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !i_rd)
            rdata_r <= 8'h00;
        else
            rdata_r <= rd_mux;
    end

    // Sample window covers the setup clocks.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            sample_r <= 1'b0;
        else
            sample_r <= (state_nxt == adsq_pkg::ST_SETUP);
    end

    // Core drive: the code under trial, and a power enable that also drops in stop mode.
    // The extra register stage plus the synchroniser still fits in the four clocks of a bit at divide by one.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            dac_r     <= 12'h000;
            core_en_r <= 1'b0;
        end
        else
        begin
            dac_r     <= trial;   // RQ1
            core_en_r <= enabled; // RQ10
        end
    end

    // Phase tick counters kept apart from the sequencer count, used only to cross-check its length.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || trigger)
        begin
            setup_seen_r <= 4'h0;
            bits_seen_r  <= 6'h00;
        end
        else if (conv_tick && (state_r == adsq_pkg::ST_SETUP))
            setup_seen_r <= setup_seen_r + 4'h1;
        else if (conv_tick && (state_r == adsq_pkg::ST_BITS))
            bits_seen_r <= bits_seen_r + 6'h01;
    end

    // Outputs.
    assign o_rdata            = rdata_r;
    assign o_core_enable      = core_en_r;            // RQ10
    assign o_channel_select   = chan_r;               // RQ14
    assign o_reference_select = ref_r;                // RQ12
    assign o_sample           = sample_r;
    assign o_dac_code         = dac_r;
    assign o_irq              = irq_r;

    // Assertions.
    property p_done_zero_off;
        @(posedge i_clk_sys) disable iff (i_rst) !enabled |=> !done_r;
    endproperty
    a_done_zero_off: assert property (p_done_zero_off) else $error("done set while disabled"); // RQ13

    property p_finish_sets;
        @(posedge i_clk_sys) disable iff (i_rst) finish && enabled |=> done_r && irq_r;
    endproperty
    a_finish_sets: assert property (p_finish_sets) else $error("finish did not set flags"); // RQ2

    property p_busy_done;
        @(posedge i_clk_sys) disable iff (i_rst) busy && i_rd && i_addr == adsq_pkg::ADDR_CTRL_LOW
            |=> !o_rdata[adsq_pkg::BIT_DONE];
    endproperty
    a_busy_done: assert property (p_busy_done) else $error("done read one while busy"); // RQ3

    property p_length;
        @(posedge i_clk_sys) disable iff (i_rst) finish |-> bits_seen_r == 6'd47 && bit_idx_r == 4'h0;
    endproperty
    a_length: assert property (p_length) else $error("conversion length wrong"); // RQ4

    property p_setup_len;
        @(posedge i_clk_sys) disable iff (i_rst) conv_tick && state_r == adsq_pkg::ST_SETUP && enabled
            |-> (state_nxt == adsq_pkg::ST_BITS) == (setup_seen_r == 4'd9);
    endproperty
    a_setup_len: assert property (p_setup_len) else $error("setup length wrong"); // RQ4

    property p_start_clear;
        @(posedge i_clk_sys) disable iff (i_rst) trigger && !wr_low |=> !start_r && busy;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start bit not cleared"); // RQ11

    property p_irq_clear;
        @(posedge i_clk_sys) disable iff (i_rst) i_irq_ack && !finish |=> !irq_r;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("ack did not clear irq"); // RQ7

    property p_align;
        @(posedge i_clk_sys) disable iff (i_rst) align_r && i_rd && i_addr == adsq_pkg::ADDR_RES_HIGH
            |=> o_rdata[7:4] == 4'h0;
    endproperty
    a_align: assert property (p_align) else $error("right justify high nibble"); // RQ6

    property p_stop;
        @(posedge i_clk_sys) disable iff (i_rst) i_stop_mode |=> !busy;
    endproperty
    a_stop: assert property (p_stop) else $error("busy in stop mode"); // RQ10
endmodule : adsq_seq

//--- bench/adsq_core_model.sv
// Behavioural analog core: per-channel input levels, multiplexer and comparator.
`timescale 1ns/100ps
module adsq_core_model
(
    // Clock.
    input  wire logic        i_clk_sys,
    // Controls from the sequencer.
    input  wire logic        i_core_enable,
    input  wire logic [3:0]  i_channel_select,
    input  wire logic [11:0] i_dac_code,
    // Input levels chosen by the bench.
    input  wire logic [15:0][11:0] i_lvl,
    // Comparator level.
    output logic             o_cmp_high
);
    // Toggles every cycle so a powered-down comparator never shows a steady level.
    logic        toggle_r = 1'b0;
    // Level of the analog input picked by the channel code.
    wire  [11:0] level = i_lvl[i_channel_select];

    // Free toggle used while the core is off.
    always_ff @(posedge i_clk_sys)
    begin
        toggle_r <= ~toggle_r;
    end

    // High while the input is at or above the trial code, which makes the search land on the level.
    assign o_cmp_high = i_core_enable ? (level >= i_dac_code) : toggle_r;
endmodule : adsq_core_model

//--- bench/tb_adsq_seq.sv
// Self-checking testbench of the converter sequencer against a behavioural result model.
`timescale 1ns/100ps
module tb_adsq_seq;
    // Design-side signals.
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic [7:0]          addr = 8'h00;
    logic [7:0]          wdata = 8'h00;
    logic                wr = 1'b0;
    logic                rd = 1'b0;
    logic [7:0]          rdata;
    logic                stop = 1'b0;
    logic                ack = 1'b0;
    adsq_pkg::adsq_tmr_t tmr = '0;
    logic                cmp;
    logic                en;
    logic [3:0]          chan;
    logic                refs;
    logic                smp;
    logic [11:0]         dac;
    logic                irq;
    // Channel levels and bookkeeping.
    logic [15:0][11:0]   lvl;
    logic [7:0]          d;
    integer              seed;
    integer              errors = 0;
    integer              total_checks = 0;
    integer              cyc = 0;

    adsq_seq adsq_seq_inst (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_stop_mode(stop), .i_irq_ack(ack), .i_tmr(tmr), .i_cmp_high(cmp), .o_core_enable(en),
        .o_channel_select(chan), .o_reference_select(refs), .o_sample(smp), .o_dac_code(dac), .o_irq(irq));
    adsq_core_model adsq_core_model_inst (.i_clk_sys(clk), .i_core_enable(en), .i_channel_select(chan),
        .i_dac_code(dac), .i_lvl(lvl), .o_cmp_high(cmp));

    // Clock of 50 ns period.
    always #25 clk = ~clk;

    // Ceiling on the whole run; the planned sequence needs well under a third of it.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            errors = errors + 1;
            stop_test();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    // Compares one byte-wide result.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    // Compares a cycle count against an allowed window.
    task automatic chk_rng(input integer got, input integer lo, input integer hi);
        total_checks = total_checks + 1;
        if (got < lo || got > hi)
        begin
            errors = errors + 1;
            $display("BAD at %0t got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask : chk_rng

    // One-cycle register write.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // One-cycle register read; the data stand only in the following cycle.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    // One-cycle pulse on the timer event picked by a trigger code of 1 to 5.
    task automatic pulse(input integer tg);
        @(posedge clk);
        tmr <= adsq_pkg::adsq_tmr_t'(5'(16 >> (tg - 1)));
        @(posedge clk);
        tmr <= '0;
    endtask : pulse

    // Runs one conversion and checks flags, routing, the aligned result and, for a software start only, the timing.
    task automatic run_conv(input integer ch, input integer ck, input integer tg, input logic al);
        integer      n;
        integer      dv;
        logic [11:0] v;
        dv = 1 << ck;
        v  = lvl[ch];
        wr_reg(8'h9d, {2'b00, 3'(tg), al, 2'(ck)});
        wr_reg(8'h9c, {1'b1, tg == 0, ch[0], 1'b0, 4'(ch)});
        if (tg != 0)
            pulse(tg);
        rd_reg(8'h9c, d);
        chk8(d, {1'b1, 1'b0, ch[0], 1'b0, 4'(ch)});
        chk8({2'b00, refs, en, chan}, {2'b00, ch[0], 1'b1, 4'(ch)});
        chk8({7'h00, smp}, 8'h01);
        n = 2;
        while (irq !== 1'b1 && n < 700)
        begin
            @(posedge clk);
            #1 n = n + 1;
        end
        if (tg == 0)
            chk_rng(n, 58 * dv, 60 * dv + 6);
        chk8({7'h00, irq}, 8'h01);
        chk8({7'h00, smp}, 8'h00);
        rd_reg(8'h9c, d);
        chk8(d, {1'b1, 1'b0, ch[0], 1'b1, 4'(ch)});
        rd_reg(8'h9f, d);
        chk8(d, al ? {4'h0, v[11:8]} : v[11:4]);
        rd_reg(8'h9e, d);
        chk8(d, al ? v[7:0] : {v[3:0], 4'h0});
        // The core is left showing the final code once the search is over.
        chk8(dac[7:0], v[7:0]);
        chk8({4'h0, dac[11:8]}, {4'h0, v[11:8]});
    endtask : run_conv

    // Main sequence.
    initial
    begin
        seed = 17;
        for (int i = 0; i < 16; i++)
            lvl[i] = 12'($random(seed));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_reg(8'h9c, d);
        chk8(d, adsq_pkg::CTRL_RESET);
        rd_reg(8'h9d, d);
        chk8(d, adsq_pkg::CTRL_RESET);
        rd_reg(8'h40, d);
        chk8(d, 8'h00);
        // Software start at every divider ratio, both alignments, random channels.
        // Only divide by eight meets the minimum conversion time of a real core; the ideal model takes any.
        for (int ck = 0; ck < 4; ck++)
            run_conv($unsigned($random(seed)) % 16, ck, 0, ck[0]);
        // Every timer trigger code, at the slowest ratio as software should choose.
        for (int tg = 1; tg < 6; tg++)
            run_conv($unsigned($random(seed)) % 16, 3, tg, tg[0]);
        // Acknowledge clears the interrupt flag.
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        @(posedge clk);
        #1 chk8({7'h00, irq}, 8'h00);
        run_conv(15, 3, 0, 1'b0);
        // Writing zero to the flag clears it; the done flag must survive.
        wr_reg(8'h9d, 8'h10);
        rd_reg(8'h9d, d);
        chk8(d, 8'h10);
        // A timer that is not selected must not start a conversion.
        pulse(1);
        wr_reg(8'h9c, 8'h8f);
        repeat (80) @(posedge clk);
        rd_reg(8'h9c, d);
        chk8(d, 8'h9f);
        // A stray conversion would have finished by now, so only the interrupt flag can tell.
        chk8({7'h00, irq}, 8'h00);
        // Unused trigger code ignores the start bit and every timer.
        wr_reg(8'h9d, 8'h30);
        wr_reg(8'h9c, 8'hcf);
        for (int tg = 1; tg < 6; tg++)
            pulse(tg);
        repeat (80) @(posedge clk);
        rd_reg(8'h9c, d);
        chk8(d, 8'hdf);
        chk8({7'h00, irq}, 8'h00);
        // Stop mode and power-off force the done flag low.
        @(posedge clk);
        stop <= 1'b1;
        rd_reg(8'h9c, d);
        chk8(d & 8'h10, 8'h00);
        @(posedge clk);
        stop <= 1'b0;
        wr_reg(8'h9c, 8'h0f);
        rd_reg(8'h9c, d);
        chk8(d & 8'hd0, 8'h00);
        chk8({7'h00, en}, 8'h00);
        // Stop mode in mid-conversion aborts it and powers the core down.
        wr_reg(8'h9d, 8'h03);
        wr_reg(8'h9c, 8'hc5);
        repeat (100) @(posedge clk);
        stop <= 1'b1;
        repeat (500) @(posedge clk);
        chk8({6'h00, en, irq}, 8'h00);
        stop <= 1'b0;
        rd_reg(8'h9c, d);
        chk8(d, 8'h85);
        stop_test();
    end
endmodule : tb_adsq_seq
